// file: rtl/ofcb_config_bank.v
`timescale 1ns/1ps
`include "ofcb_map.vh"
module ofcb_config_bank #(
	parameter WORD_W = 16,                         // control word width
	parameter CORNER_W = 7                         // rf corner code width
) (
	input  wire                clk_i,              // system clock
	input  wire                nrst_i,             // power-on reset, active low
	input  wire                wr_stb_i,           // one-cycle word strobe
	input  wire [WORD_W-1:0]   wr_word_i,          // control word
	input  wire                extended_map_select_i, // extended field meanings
	input  wire                power_on_control_i, // host power-on command
	input  wire                short_laser_cmd_i,  // short-wave laser command
	input  wire                long_laser_cmd_i,   // long-wave laser command
	input  wire                sum_input_select_i, // data path source
	input  wire                focus_offset_dac_on_i, // focus dac enable
	input  wire [7:0]          channel_polarity_switch_i, // 2 bits per channel
	input  wire                dac_split_i,        // 1 = independent left/right
	output reg  [WORD_W-1:0]   rf_filter_settings_o,  // rf filter readback
	output reg  [WORD_W-1:0]   phase_detector_filter_settings_o, // pd readback
	output reg                 noise_filter_on_o,  // noise filter enable
	output reg                 equalizer_on_o,     // equalizer enable
	output reg                 boost_select_o,     // boost high
	output reg  [CORNER_W-1:0] rf_corner_code_o,   // shared corner code
	output reg  [2:0]          leadlag_start_code_o, // lead/lag start
	output reg  [2:0]          phase_lowpass_code_o, // low-pass corner
	output reg                 powered_state_o,    // device powered
	output reg                 short_wave_laser_status_o, // laser status
	output reg                 long_wave_laser_status_o,  // laser status
	output reg                 short_laser_supply_o, // laser supply enable
	output reg                 long_laser_supply_o,  // laser supply enable
	output reg                 servo_outputs_off_mode_o, // servo-off mode
	output reg  [3:0]          focus_output_oe_n_o, // focus a..d drive, low = driven
	output reg                 radial_output_one_oe_n_o, // low = driven
	output reg                 radial_output_two_oe_n_o, // low = driven
	output reg  [2:0]          radial_tracking_mode_o, // tracking mode
	output reg                 phase_tracking_detector_on_o, // tracker active
	output reg                 sum_path_select_o,  // 1 = sum inputs feed data
	output reg                 focus_offset_apply_o, // dac adds to focus
	output reg  [3:0]          channel_pass_o,     // per channel pass
	output reg  [3:0]          channel_invert_o,   // per channel invert
	output reg  [7:0]          left_offset_dac_o,  // left rf offset value
	output reg  [7:0]          right_offset_dac_o  // right rf offset value
);

	// ****************************************
	// word decode
	// ****************************************
	wire [3:0] addr = wr_word_i[`OFCB_ADDR_MSB:`OFCB_ADDR_LSB];
	wire       wr_rf = wr_stb_i & (addr == `OFCB_ADDR_RF_FILT);
	wire       wr_pd = wr_stb_i & (addr == `OFCB_ADDR_PD_FILT);
	wire       wr_r1 = wr_stb_i & (addr == `OFCB_ADDR_REG1);
	wire       wr_r4 = wr_stb_i & (addr == `OFCB_ADDR_REG4);
	wire       wr_r5 = wr_stb_i & (addr == `OFCB_ADDR_REG5);
	wire       wr_rd = wr_stb_i & (addr == `OFCB_ADDR_REGD);

	// stored fields
	reg [9:0] rf_reg;                  // rf filter fields
	reg [5:0] pd_reg;                  // pd filter fields
	reg [2:0] rt_reg;                  // tracking mode
	reg [7:0] dac4_reg;                // offset dac register 4
	reg [7:0] dac5_reg;                // offset dac register 5
	reg       servo_off_reg;           // servo-off mode bit
	reg       pwr_reg;                 // synchronised power state

	// ****************************************
	// register writes
	// ****************************************
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			rf_reg        <= `OFCB_RF_RESET;
			pd_reg        <= `OFCB_PD_RESET;
			rt_reg        <= 3'h0;
			dac4_reg      <= 8'h00;
			dac5_reg      <= 8'h00;
			servo_off_reg <= 1'b0;
			pwr_reg       <= 1'b0;     // start in standby
		end else begin
			pwr_reg <= power_on_control_i;
			if (wr_rf) begin
				// bits 11,10 dropped
				rf_reg <= wr_word_i[9:0];
			end
			if (wr_pd) begin
				// bits 11..6 dropped
				pd_reg <= wr_word_i[`OFCB_LL_MSB:`OFCB_LPF_LSB];
			end
			if (wr_r1) begin
				rt_reg <= wr_word_i[`OFCB_RT_MSB:`OFCB_RT_LSB];
			end
			if (wr_r4) begin
				dac4_reg <= wr_word_i[`OFCB_DAC_MSB:`OFCB_DAC_LSB];
			end
			if (wr_r5) begin
				dac5_reg <= wr_word_i[`OFCB_DAC_MSB:`OFCB_DAC_LSB];
			end
			if (wr_rd) begin
				servo_off_reg <= wr_word_i[`OFCB_SERVO_OFF_BIT];
			end
		end
	end

	// ****************************************
	// per channel switch decode
	// ****************************************
	// code 01 pass, 11 invert, 00/10 block
	// pass and invert are exclusive, so a channel never does both
	wire [3:0] pass_next;              // decoded pass
	wire [3:0] inv_next;               // decoded invert
	genvar     ch;                     // channel index
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
			// low bit set, high bit clear: straight through
			assign pass_next[ch] = channel_polarity_switch_i[2*ch] &
			                       ~channel_polarity_switch_i[2*ch+1];
			// both bits set: sign flipped
			assign inv_next[ch]  = channel_polarity_switch_i[2*ch] &
			                       channel_polarity_switch_i[2*ch+1];
		end
	endgenerate

	// ****************************************
	// readback images
	// ****************************************
	// rebuild each filter word with its own address on top
	// unused bits always read back as zero, whatever was written
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			rf_filter_settings_o             <= 16'h0000; // cleared image
			phase_detector_filter_settings_o <= 16'h0000; // cleared image
		end else begin
			// rf bits 11,10 show zero
			rf_filter_settings_o             <= {`OFCB_ADDR_RF_FILT, 2'b00, rf_reg};
			// pd bits 11..6 show zero
			phase_detector_filter_settings_o <= {`OFCB_ADDR_PD_FILT, 6'h00, pd_reg};
		end
	end

	// ****************************************
	// filter controls
	// ****************************************
	// fields only mean something in the extended map, and standby
	// parks the whole filter section so nothing half-configured runs
	wire filt_live = extended_map_select_i & pwr_reg;

	// equalizer, noise filter and shared corner code
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			noise_filter_on_o <= 1'b0;             // filter off
			equalizer_on_o    <= 1'b0;             // equalizer off
			boost_select_o    <= 1'b0;             // low boost
			rf_corner_code_o  <= {CORNER_W{1'b0}}; // lowest corner
		end else if (filt_live) begin
			// live settings follow the stored word
			noise_filter_on_o <= rf_reg[`OFCB_NF_BIT];
			equalizer_on_o    <= rf_reg[`OFCB_EQ_BIT];
			boost_select_o    <= rf_reg[`OFCB_BOOST_BIT];
			// one code drives both filters' corner
			rf_corner_code_o  <= rf_reg[`OFCB_CORNER_MSB:`OFCB_CORNER_LSB];
		end else begin
			// parked: everything back to its quiet value
			noise_filter_on_o <= 1'b0;
			equalizer_on_o    <= 1'b0;
			boost_select_o    <= 1'b0;
			rf_corner_code_o  <= {CORNER_W{1'b0}};
		end
	end

	// phase detector lead/lag and low-pass codes
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			leadlag_start_code_o <= 3'h0; // lowest start
			phase_lowpass_code_o <= 3'h0; // lowest corner
		end else if (filt_live) begin
			// codes above the listed ones pass through unchanged
			leadlag_start_code_o <= pd_reg[`OFCB_LL_MSB:`OFCB_LL_LSB];
			phase_lowpass_code_o <= pd_reg[`OFCB_LPF_MSB:`OFCB_LPF_LSB];
		end else begin
			// parked codes
			leadlag_start_code_o <= 3'h0;
			phase_lowpass_code_o <= 3'h0;
		end
	end

	// ****************************************
	// power and lasers
	// ****************************************
	// a laser only lights, and only reports lit, while powered
	// supply and status share the same term so they never disagree
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			powered_state_o           <= 1'b0; // standby
			short_laser_supply_o      <= 1'b0; // supply off
			long_laser_supply_o       <= 1'b0; // supply off
			short_wave_laser_status_o <= 1'b0; // reads off
			long_wave_laser_status_o  <= 1'b0; // reads off
		end else begin
			// second stage of the power path
			powered_state_o           <= pwr_reg;
			// supplies cut in standby
			short_laser_supply_o      <= short_laser_cmd_i & pwr_reg;
			long_laser_supply_o       <= long_laser_cmd_i & pwr_reg;
			// status needs command and power
			short_wave_laser_status_o <= short_laser_cmd_i & pwr_reg;
			long_wave_laser_status_o  <= long_laser_cmd_i & pwr_reg;
		end
	end

	// ****************************************
	// servo output enables
	// ****************************************
	// servo pins let go in servo-off mode so a second front end can
	// drive the same lines; standby lets go as well
	wire servo_release = servo_off_reg | ~pwr_reg;

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			servo_outputs_off_mode_o <= 1'b0; // normal mode
			focus_output_oe_n_o      <= 4'hF; // all released
			radial_output_one_oe_n_o <= 1'b1; // released
			radial_output_two_oe_n_o <= 1'b1; // released
		end else begin
			// mode bit mirrored out
			servo_outputs_off_mode_o <= servo_off_reg;
			// all four focus pins together
			focus_output_oe_n_o      <= {4{servo_release}};
			// both radial pins together
			radial_output_one_oe_n_o <= servo_release;
			radial_output_two_oe_n_o <= servo_release;
		end
	end

	// ****************************************
	// tracking
	// ****************************************
	// mode zero leaves the phase tracker idle
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			radial_tracking_mode_o       <= 3'h0; // idle mode
			phase_tracking_detector_on_o <= 1'b0; // tracker idle
		end else begin
			// field copied straight out
			radial_tracking_mode_o       <= rt_reg;
			// any nonzero mode runs the tracker while powered
			phase_tracking_detector_on_o <= pwr_reg & (rt_reg != 3'h0);
		end
	end

	// ****************************************
	// data path and focus dac
	// ****************************************
	// source choice is kept in standby; only the dac is gated
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			sum_path_select_o    <= 1'b0; // diode inputs
			focus_offset_apply_o <= 1'b0; // dac not added
		end else begin
			// 0 diodes, 1 sum pair
			sum_path_select_o    <= sum_input_select_i;
			// dac adds only when enabled and powered
			focus_offset_apply_o <= focus_offset_dac_on_i & pwr_reg;
		end
	end

	// ****************************************
	// channel switches
	// ****************************************
	// decoded per channel above, registered here
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			channel_pass_o   <= 4'h0; // all blocked
			channel_invert_o <= 4'h0; // none inverted
		end else begin
			channel_pass_o   <= pass_next;
			channel_invert_o <= inv_next;
		end
	end

	// ****************************************
	// offset dacs
	// ****************************************
	// shared mode feeds both sides from register 4; split mode gives
	// the right side its own value from register 5
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			left_offset_dac_o  <= 8'h00; // zero offset
			right_offset_dac_o <= 8'h00; // zero offset
		end else begin
			// left always from register 4
			left_offset_dac_o  <= dac4_reg;
			if (dac_split_i) begin
				// independent right value
				right_offset_dac_o <= dac5_reg;
			end else begin
				// shared with left
				right_offset_dac_o <= dac4_reg;
			end
		end
	end

endmodule // ofcb_config_bank

// file: rtl/ofcb_map.vh
`ifndef OFCB_MAP_VH
`define OFCB_MAP_VH
// ****************************************
// register addresses (upper nibble of word)
// ****************************************
`define OFCB_ADDR_REG1      4'h1
`define OFCB_ADDR_REG4      4'h4
`define OFCB_ADDR_REG5      4'h5
`define OFCB_ADDR_REGD      4'hD
`define OFCB_ADDR_RF_FILT   4'hE
`define OFCB_ADDR_PD_FILT   4'hF
// ****************************************
// word field positions
// ****************************************
`define OFCB_ADDR_MSB       15
`define OFCB_ADDR_LSB       12
`define OFCB_NF_BIT         9
`define OFCB_EQ_BIT         8
`define OFCB_BOOST_BIT      7
`define OFCB_CORNER_MSB     6
`define OFCB_CORNER_LSB     0
`define OFCB_LL_MSB         5
`define OFCB_LL_LSB         3
`define OFCB_LPF_MSB        2
`define OFCB_LPF_LSB        0
`define OFCB_SERVO_OFF_BIT  11
`define OFCB_RT_MSB         2
`define OFCB_RT_LSB         0
`define OFCB_DAC_MSB        7
`define OFCB_DAC_LSB        0
// ****************************************
// reset values and used-bit masks
// ****************************************
`define OFCB_RF_RESET       10'h000
`define OFCB_PD_RESET       6'h00
`define OFCB_RF_MASK        16'h03FF
`define OFCB_PD_MASK        16'h003F
`endif

// file: verification/ofcb_host.sv
`timescale 1ns/1ps
// ****************************************
// host side: writes control words
// ****************************************
module ofcb_host (
	input  wire logic        clk_i,     // system clock
	output logic             wr_stb_o,  // word strobe
	output logic [15:0]      wr_word_o  // control word
);
	// idle bus at time zero
	initial begin
		wr_stb_o = 1'b0;
		wr_word_o = 16'h0000;
	end
	// one whole word per strobe, then strobe dropped and word inverted
	task send(input logic [15:0] w);
		@(posedge clk_i) #1;
		wr_stb_o = 1'b1;
		wr_word_o = w;
		@(posedge clk_i) #1;
		wr_stb_o = 1'b0;
		wr_word_o = ~w;
	endtask
endmodule // ofcb_host

// file: verification/ofcb_sva.sv
`timescale 1ns/1ps
// ****************************************
// port checker for the config bank
// ****************************************
module ofcb_sva #(
	parameter WORD_W   = 16,
	parameter CORNER_W = 7
) (
	input wire logic                clk_i,
	input wire logic                nrst_i,
	input wire logic                wr_stb_i,
	input wire logic [WORD_W-1:0]   wr_word_i,
	input wire logic                extended_map_select_i,
	input wire logic                power_on_control_i,
	input wire logic                short_laser_cmd_i,
	input wire logic [WORD_W-1:0]   rf_filter_settings_o,
	input wire logic [WORD_W-1:0]   phase_detector_filter_settings_o,
	input wire logic                noise_filter_on_o,
	input wire logic [CORNER_W-1:0] rf_corner_code_o,
	input wire logic [2:0]          leadlag_start_code_o,
	input wire logic                powered_state_o,
	input wire logic                short_wave_laser_status_o,
	input wire logic                servo_outputs_off_mode_o,
	input wire logic [3:0]          focus_output_oe_n_o
);
	logic [2:0] q_reg;  // cycles with quiet inputs
	logic [2:0] l_reg;  // last level inputs
	wire  [2:0] now = {extended_map_select_i, power_on_control_i, short_laser_cmd_i};
	wire        st = (q_reg >= 3'd4);                    // outputs settled
	wire        on = st && powered_state_o && extended_map_select_i;
	// settle counter, cleared by writes and input changes
	always @(posedge clk_i) begin
		l_reg <= now;
		if (!nrst_i || wr_stb_i || l_reg != now) q_reg <= 3'd0;
		else if (q_reg != 3'd7) q_reg <= q_reg + 3'd1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_rf; wr_stb_i && wr_word_i[15:12] == 4'hE |-> ##2
		rf_filter_settings_o == {4'hE, 2'h0, $past(wr_word_i[9:0], 2)}; endproperty
	property p_pd; wr_stb_i && wr_word_i[15:12] == 4'hF |-> ##2
		phase_detector_filter_settings_o == {4'hF, 6'h0, $past(wr_word_i[5:0], 2)}; endproperty
	property p_nf; on |-> noise_filter_on_o == rf_filter_settings_o[9]; endproperty
	property p_bw; on |-> rf_corner_code_o == rf_filter_settings_o[6:0]; endproperty
	property p_ll; on |-> leadlag_start_code_o == phase_detector_filter_settings_o[5:3]; endproperty
	property p_off; st && !extended_map_select_i |-> rf_corner_code_o == 0 && !noise_filter_on_o;
	endproperty
	property p_por; $rose(nrst_i) |-> !powered_state_o ##1 !powered_state_o; endproperty
	property p_las; st |-> short_wave_laser_status_o == (short_laser_cmd_i && powered_state_o);
	endproperty
	property p_hiz; st && servo_outputs_off_mode_o |-> focus_output_oe_n_o == 4'hF; endproperty
	a_rf: assert property (p_rf) else $error("rf readback wrong");
	a_pd: assert property (p_pd) else $error("pd readback wrong");
	a_nf: assert property (p_nf) else $error("noise filter wrong");
	a_bw: assert property (p_bw) else $error("corner code wrong");
	a_ll: assert property (p_ll) else $error("lead lag wrong");
	a_off: assert property (p_off) else $error("fields not gated");
	a_por: assert property (p_por) else $error("powered after reset");
	a_las: assert property (p_las) else $error("laser status wrong");
	a_hiz: assert property (p_hiz) else $error("servo pins driven");
	c_rf: cover property (wr_stb_i && wr_word_i[15:12] == 4'hE);
	c_hiz: cover property (st && servo_outputs_off_mode_o);
	c_las: cover property (st && short_wave_laser_status_o);
endmodule // ofcb_sva
bind ofcb_config_bank ofcb_sva #(.WORD_W(WORD_W), .CORNER_W(CORNER_W)) u_sva (.*);

// file: verification/testbench.sv
`timescale 1ns/1ps
// ****************************************
// self-checking bench
// ****************************************
module testbench;
	logic clk_i, nrst_i, extended_map_select_i, power_on_control_i, short_laser_cmd_i;
	logic long_laser_cmd_i, sum_input_select_i, focus_offset_dac_on_i, dac_split_i;
	logic [7:0] channel_polarity_switch_i;
	wire wr_stb_i, noise_filter_on_o, equalizer_on_o, boost_select_o, powered_state_o;
	wire short_wave_laser_status_o, long_wave_laser_status_o, short_laser_supply_o;
	wire long_laser_supply_o, servo_outputs_off_mode_o, radial_output_one_oe_n_o;
	wire radial_output_two_oe_n_o, phase_tracking_detector_on_o, sum_path_select_o;
	wire focus_offset_apply_o;
	wire [15:0] wr_word_i, rf_filter_settings_o, phase_detector_filter_settings_o;
	wire [6:0] rf_corner_code_o;
	wire [2:0] leadlag_start_code_o, phase_lowpass_code_o, radial_tracking_mode_o;
	wire [3:0] focus_output_oe_n_o, channel_pass_o, channel_invert_o;
	wire [7:0] left_offset_dac_o, right_offset_dac_o;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	ofcb_config_bank dut (.*);
	ofcb_host h (.clk_i(clk_i), .wr_stb_o(wr_stb_i), .wr_word_o(wr_word_i));
	// compare one value
	task ck(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// wait edges, then step off the edge
	task wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// laser gating by power
	task t_las;
		short_laser_cmd_i = 1'b1;
		long_laser_cmd_i = 1'b1;
		wt(4);
		ck({short_wave_laser_status_o, long_wave_laser_status_o}, 0);
		ck({short_laser_supply_o, long_laser_supply_o}, 0);
		ck({focus_output_oe_n_o, radial_output_one_oe_n_o, radial_output_two_oe_n_o}, 6'h3F);
		power_on_control_i = 1'b1;
		wt(4);
		ck({short_wave_laser_status_o, long_wave_laser_status_o}, 2'b11);
		ck(focus_output_oe_n_o, 4'h0);
		$display("laser test done");
	endtask
	// filter registers, unused bits, unmapped address
	task t_filt;
		extended_map_select_i = 1'b1;
		h.send(16'hEFFF);
		wt(3);
		ck(rf_filter_settings_o, 16'hE3FF);
		ck({noise_filter_on_o, equalizer_on_o, boost_select_o, rf_corner_code_o}, 10'h3FF);
		h.send(16'hE12A);
		h.send(16'h2FFF);
		h.send(16'hFFE7);
		wt(3);
		ck({noise_filter_on_o, equalizer_on_o, boost_select_o, rf_corner_code_o}, 10'h12A);
		ck(rf_filter_settings_o, 16'hE12A);
		ck(phase_detector_filter_settings_o, 16'hF027);
		ck({leadlag_start_code_o, phase_lowpass_code_o}, 6'h27);
		extended_map_select_i = 1'b0;
		wt(4);
		ck({noise_filter_on_o, rf_corner_code_o, leadlag_start_code_o}, 0);
		$display("filter test done");
	endtask
	// servo-off mode on and off
	task t_rfo;
		h.send(16'hD800);
		wt(3);
		ck({servo_outputs_off_mode_o, focus_output_oe_n_o, radial_output_one_oe_n_o}, 6'h3F);
		h.send(16'hD000);
		wt(3);
		ck({servo_outputs_off_mode_o, radial_output_two_oe_n_o}, 0);
		$display("servo-off test done");
	endtask
	// switches, dacs, data source, tracking
	task t_misc;
		channel_polarity_switch_i = 8'hD2;
		sum_input_select_i = 1'b1;
		focus_offset_dac_on_i = 1'b1;
		h.send(16'h40AB);
		h.send(16'h5034);
		h.send(16'h1003);
		wt(3);
		ck({channel_pass_o, channel_invert_o}, 8'h48);
		ck({left_offset_dac_o, right_offset_dac_o}, 16'hABAB);
		ck(sum_path_select_o, 1'b1);
		ck(focus_offset_apply_o, 1'b1);
		ck({radial_tracking_mode_o, phase_tracking_detector_on_o}, 4'h7);
		dac_split_i = 1'b1;
		power_on_control_i = 1'b0;
		wt(4);
		ck(right_offset_dac_o, 8'h34);
		ck({short_laser_supply_o, long_laser_supply_o, powered_state_o}, 0);
		channel_polarity_switch_i = 8'h37;
		sum_input_select_i = 1'b0;
		focus_offset_dac_on_i = 1'b0;
		long_laser_cmd_i = 1'b0;
		dac_split_i = 1'b0;
		power_on_control_i = 1'b1;
		wt(4);
		ck({channel_pass_o, channel_invert_o}, 8'h25);
		ck(sum_path_select_o, 1'b0);
		ck(focus_offset_apply_o, 1'b0);
		ck(right_offset_dac_o, 8'hAB);
		ck({short_laser_supply_o, long_laser_supply_o}, 2'b10);
		ck({short_wave_laser_status_o, long_wave_laser_status_o}, 2'b10);
		$display("misc test done");
	endtask
	// verdict and end of run
	task summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			summarize;
		end
	end
	// main sequence
	initial begin
		{nrst_i, extended_map_select_i, power_on_control_i, short_laser_cmd_i} = 4'h0;
		{long_laser_cmd_i, sum_input_select_i, focus_offset_dac_on_i, dac_split_i} = 4'h0;
		channel_polarity_switch_i = 8'h00;
		wt(4);
		nrst_i = 1'b1;
		t_las;
		t_filt;
		t_rfo;
		t_misc;
		summarize;
	end
endmodule // testbench
